// *** design/hif_adc_host.sv ***
`timescale 1ns/1ps
`include "hif_defs.svh"
module hif_adc_host #(
    parameter int SCLK_HALF = 4,
    parameter int TOUT_CYC = `HIF_TOUT_CYC
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_mode,
    input wire logic i_eoc_n,
    input wire logic [11:0] i_db,
    input wire logic i_sdout,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output hif_pkg::hif_par_t o_par,
    output hif_pkg::hif_ser_t o_ser,
    output logic o_busy
);
    if (TOUT_CYC < `HIF_CONV_CYC || TOUT_CYC > 65535) begin : g_chk
        $error("TOUT_CYC out of range");
    end

    logic [14:0] sync_q; // Synchronised pins: mode, done line, data, serial out.
    logic mode_s; // Synchronised mode strap.
    logic eoc_n_s; // Synchronised done line.
    logic [11:0] db_s; // Synchronised parallel data.
    logic sdout_s; // Synchronised serial out.
    hif_pkg::hif_state_t state; // Sequencer state.
    logic [5:0] cfg; // Control word that software sets up.
    logic [5:0] tx; // Control word snapshot taken at start.
    logic [15:0] rx; // Serial receive shifter.
    logic [15:0] result; // Last complete result word.
    logic [15:0] cnt; // Strobe widths and done-line timeout.
    logic [4:0] nfall; // Falling serial edges seen in this frame.
    logic [4:0] nrise; // Rising serial edges seen in this frame.
    logic mode; // Mode caught when a sequence starts.
    logic done; // Sticky completion flag.
    logic tout; // Sticky timeout flag.
    logic start; // Software start, taken only when idle.
    logic stat_wr; // Write to the status register.
    logic sclk_run; // Serial clock enable.
    logic sclk_rise; // Serial clock rises on this edge.
    logic sclk_fall; // Serial clock falls on this edge.
    logic sclk; // Serial clock pin value.
    logic finish; // Sequence completes on this edge.
    logic rd_frame_n; // Read frame pin value.
    logic wr_frame_n; // Write frame pin value.
    logic sdin_q; // Serial data towards the converter.

    hif_sync #(.WIDTH(15)) u_sync (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_d({i_mode, i_eoc_n, i_db, i_sdout}),
        .o_q(sync_q)
    );
    assign {mode_s, eoc_n_s, db_s, sdout_s} = sync_q;

    hif_sclk_gen #(.HALF(SCLK_HALF)) u_sclk (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_run(sclk_run),
        .o_sclk(sclk),
        .o_rise(sclk_rise),
        .o_fall(sclk_fall)
    );

    // The host makes the serial clock itself and runs it only inside a frame.
    assign sclk_run = (state == hif_pkg::ST_S_XFER) && (nfall != 5'(`HIF_SER_BITS));
    assign start = i_wr && (i_addr == `HIF_REG_CMD) && i_wdata[`HIF_CMD_GO] && (state == hif_pkg::ST_IDLE);
    assign stat_wr = i_wr && (i_addr == `HIF_REG_STAT);
    assign finish = (state == hif_pkg::ST_S_END) ||
                    (state == hif_pkg::ST_P_READ && cnt == 16'(`HIF_RD_CYC - 1));
    assign o_busy = (state != hif_pkg::ST_IDLE);

    // Configuration register; the control word is sent as written.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cfg <= `HIF_CFG_RST;
        end else if (i_wr && i_addr == `HIF_REG_CFG) begin
            cfg <= i_wdata[5:0]; // Address, soft start, standby, format.
        end
    end

    // Read port: data appear in the cycle after the read strobe only.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            unique case (i_addr)
                `HIF_REG_CFG: o_rdata <= {26'h0, cfg};
                `HIF_REG_STAT: o_rdata <= {28'h0, tout, mode, done, o_busy};
                `HIF_REG_RES: o_rdata <= {16'h0, result};
                default: o_rdata <= 32'h0000_0000; // Unmapped offsets read zero.
            endcase
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    // Sticky flags: an event in the clearing cycle wins over the clear.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            done <= 1'b0;
            tout <= 1'b0;
        end else begin
            if (finish) begin
                done <= 1'b1;
            end else if (stat_wr && i_wdata[`HIF_STAT_DONE]) begin
                done <= 1'b0;
            end
            if (state == hif_pkg::ST_P_WAIT && cnt == 16'(TOUT_CYC - 1) && eoc_n_s) begin
                tout <= 1'b1;
            end else if (stat_wr && i_wdata[`HIF_STAT_TOUT]) begin
                tout <= 1'b0;
            end
        end
    end

    // Sequencer. The mode strap is only looked at when a sequence starts,
    // so a strap that moves mid-transfer cannot tear a sequence in half.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= hif_pkg::ST_IDLE;
            mode <= 1'b0;
            tx <= `HIF_CFG_RST;
            cnt <= 16'h0000;
        end else begin
            unique case (state)
                hif_pkg::ST_IDLE: begin
                    cnt <= 16'h0000;
                    if (start) begin
                        mode <= mode_s;
                        tx <= cfg;
                        state <= mode_s ? hif_pkg::ST_P_ADDR : hif_pkg::ST_S_XFER;
                    end
                end
                hif_pkg::ST_P_ADDR: begin
                    // Store strobe low; its rising edge latches the address.
                    if (cnt == 16'(`HIF_STROBE_CYC - 1)) begin
                        cnt <= 16'h0000;
                        // A soft start needs no trigger pulse from the host.
                        state <= tx[`HIF_CFG_SOFT] ? hif_pkg::ST_P_WAIT : hif_pkg::ST_P_TRIG;
                    end else begin
                        cnt <= cnt + 16'h0001;
                    end
                end
                hif_pkg::ST_P_TRIG: begin
                    if (cnt == 16'(`HIF_STROBE_CYC - 1)) begin
                        cnt <= 16'h0000;
                        state <= hif_pkg::ST_P_WAIT;
                    end else begin
                        cnt <= cnt + 16'h0001;
                    end
                end
                hif_pkg::ST_P_WAIT: begin
                    // A done pulse starts the read at once.
                    if (!eoc_n_s) begin
                        cnt <= 16'h0000;
                        state <= hif_pkg::ST_P_READ;
                    end else if (cnt == 16'(TOUT_CYC - 1)) begin
                        state <= hif_pkg::ST_IDLE; // No done pulse: give up.
                    end else begin
                        cnt <= cnt + 16'h0001;
                    end
                end
                hif_pkg::ST_P_READ: begin
                    // Held long enough for the data to cross the synchroniser.
                    if (cnt == 16'(`HIF_RD_CYC - 1)) begin
                        state <= hif_pkg::ST_IDLE;
                    end else begin
                        cnt <= cnt + 16'h0001;
                    end
                end
                hif_pkg::ST_S_XFER: begin
                    if (nfall == 5'(`HIF_SER_BITS)) begin
                        state <= hif_pkg::ST_S_END;
                    end
                end
                hif_pkg::ST_S_END: begin
                    state <= hif_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Serial bit counters and the receive shifter.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            nfall <= 5'h00;
            nrise <= 5'h00;
            rx <= 16'h0000;
        end else if (state != hif_pkg::ST_S_XFER) begin
            nfall <= 5'h00;
            nrise <= 5'h00;
        end else begin
            if (sclk_rise) begin
                nrise <= nrise + 5'h01;
            end
            if (sclk_fall) begin
                nfall <= nfall + 5'h01;
                rx <= {rx[14:0], sdout_s}; // Sampled on the falling edge.
            end
        end
    end

    // Result word: parallel reads are padded to the serial layout.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            result <= 16'h0000;
        end else if (state == hif_pkg::ST_S_END) begin
            result <= rx;
        end else if (state == hif_pkg::ST_P_READ && cnt == 16'(`HIF_RD_CYC - 1)) begin
            result <= {tx[`HIF_CFG_FMT], tx[5:3], db_s};
        end
    end

    // Serial pins. Both frames move together, so one frame writes the
    // control word and reads the last result.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_frame_n <= 1'b1;
            wr_frame_n <= 1'b1;
            sdin_q <= 1'b0;
        end else begin
            // Frames fall on entry and stay low to the last bit.
            rd_frame_n <= !(next_frame(state, start, mode_s));
            wr_frame_n <= !(next_frame(state, start, mode_s));
            if (sclk_rise) begin
                // Bit changes on the rise, so it is settled at the fall.
                sdin_q <= (nrise < 5'(`HIF_CTL_BITS)) ? tx[3'(5 - nrise)] : 1'b0;
            end else if (state != hif_pkg::ST_S_XFER) begin
                sdin_q <= 1'b0;
            end
        end
    end
    // One driver for the whole bundle keeps the serial pins in a single process each.
    assign o_ser = '{sclk: sclk, serial_read_frame_n: rd_frame_n, serial_write_frame_n: wr_frame_n, sdin: sdin_q};

    function automatic logic next_frame(input hif_pkg::hif_state_t s, input logic go, input logic m);
        next_frame = (s == hif_pkg::ST_S_XFER && nfall != 5'(`HIF_SER_BITS)) || (go && !m);
    endfunction

    // Parallel pins. Outside the parallel sequence every strobe stays high
    // and the lines are driven low, which also covers serial mode.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_par <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, sample_trigger_n: 1'b1, db: 12'h000, db_oe: 1'b1};
        end else begin
            o_par.wr_n <= !(state == hif_pkg::ST_IDLE ? (start && mode_s) :
                           (state == hif_pkg::ST_P_ADDR && cnt != 16'(`HIF_STROBE_CYC - 1)));
            o_par.sample_trigger_n <= !(state == hif_pkg::ST_P_TRIG && cnt != 16'(`HIF_STROBE_CYC - 1));
            o_par.cs_n <= !(state == hif_pkg::ST_P_WAIT ? !eoc_n_s :
                           (state == hif_pkg::ST_P_READ && cnt != 16'(`HIF_RD_CYC - 1)));
            o_par.rd_n <= !(state == hif_pkg::ST_P_WAIT ? !eoc_n_s :
                           (state == hif_pkg::ST_P_READ && cnt != 16'(`HIF_RD_CYC - 1)));
            // The control word is driven while the store strobe is low.
            if (state == hif_pkg::ST_IDLE && start && mode_s) begin
                o_par.db <= {6'h00, cfg};
                o_par.db_oe <= 1'b1;
            end else if (state == hif_pkg::ST_P_WAIT && !eoc_n_s) begin
                o_par.db <= 12'h000;
                o_par.db_oe <= 1'b0; // Device owns the lines while reading.
            end else if (state == hif_pkg::ST_P_READ) begin
                o_par.db_oe <= (cnt == 16'(`HIF_RD_CYC - 1));
            end else if (state != hif_pkg::ST_P_ADDR) begin
                o_par.db <= 12'h000;
                o_par.db_oe <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    a_frames_tied: assert property ((o_ser.serial_read_frame_n == o_ser.serial_write_frame_n) &&
        (o_ser.serial_read_frame_n || o_busy))
        else $error("frames differ");
    a_frame_held: assert property ($rose(sclk) |-> !o_ser.serial_read_frame_n [*2])
        else $error("read frame high during clock");
    a_frame_first: assert property ($rose(sclk) |-> $past(!o_ser.serial_write_frame_n, 3))
        else $error("write frame not low before clock");
    a_clk_in_frame: assert property (sclk |-> state == hif_pkg::ST_S_XFER)
        else $error("serial clock outside frame");
    a_din_setup: assert property ($fell(sclk) |-> $stable(o_ser.sdin))
        else $error("data in moved at falling edge");
    a_bit_count: assert property (state == hif_pkg::ST_S_END |-> nfall == 5'(`HIF_SER_BITS))
        else $error("wrong serial bit count");
    a_quiet_strobes: assert property (!o_busy || !mode |-> ##1 o_par.cs_n && o_par.rd_n && o_par.db_oe)
        else $error("parallel pins active when idle");
    a_store_addr: assert property ($rose(o_par.wr_n) |-> o_par.db_oe && o_par.db[5:0] == tx)
        else $error("address not on lines at store edge");
    a_read_pair: assert property (o_par.cs_n == o_par.rd_n)
        else $error("select and read differ");
    a_done_read: assert property (state == hif_pkg::ST_P_WAIT && !eoc_n_s |=> ##[0:1] !o_par.rd_n)
        else $error("no read after done pulse");
    a_mode_route: assert property (start |=> (mode == $past(mode_s)) &&
        (mode ? (!o_par.wr_n && o_ser.serial_read_frame_n) : (o_par.wr_n && !o_ser.serial_read_frame_n)))
        else $error("wrong interface for mode");

    c_par_done: cover property (state == hif_pkg::ST_P_READ ##1 state == hif_pkg::ST_IDLE);
    c_ser_done: cover property (state == hif_pkg::ST_S_END);
    c_timeout: cover property ($rose(tout));
    c_set_wins: cover property (finish && stat_wr && i_wdata[`HIF_STAT_DONE]);
endmodule

// *** design/hif_sclk_gen.sv ***
`timescale 1ns/1ps
// Serial clock divider; idles low and starts with a full low half period.
module hif_sclk_gen #(
    parameter int HALF = 4
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_run,
    output logic o_sclk,
    output logic o_rise,
    output logic o_fall
);
    logic [7:0] cnt; // Cycles into the current half period.
    logic wrap; // Last cycle of a half period.

    if (HALF < 4 || HALF > 255) begin : g_chk
        $error("HALF must lie in 4..255");
    end

    assign wrap = i_run && (cnt == 8'(HALF - 1));
    // The edge pulses flag the clock edge on which the pin toggles.
    assign o_rise = wrap && !o_sclk;
    assign o_fall = wrap && o_sclk;

    // Half-period counter; cleared whenever the clock is stopped.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt <= 8'h00;
            o_sclk <= 1'b0;
        end else if (!i_run) begin
            cnt <= 8'h00;
            o_sclk <= 1'b0;
        end else if (wrap) begin
            cnt <= 8'h00;
            o_sclk <= !o_sclk;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule

// *** design/hif_sync.sv ***
`timescale 1ns/1ps
// Two-flop synchroniser for pins from outside the clock domain.
module hif_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);
    logic [WIDTH-1:0] meta; // First stage, read only by the second.

    // Both stages reset to zero; callers treat early values as idle.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta <= '0;
            o_q <= '0;
        end else begin
            meta <= i_d;
            o_q <= meta;
        end
    end
endmodule

// *** shared/hif_defs.svh ***
`ifndef HIF_DEFS_SVH
`define HIF_DEFS_SVH
// Register offsets of the host's own register port.
`define HIF_REG_CFG 4'h0
`define HIF_REG_CMD 4'h4
`define HIF_REG_STAT 4'h8
`define HIF_REG_RES 4'hc
// Control word fields, bit 5 goes out first.
`define HIF_CFG_CH_LSB 3
`define HIF_CFG_SOFT 2
`define HIF_CFG_STBY 1
`define HIF_CFG_FMT 0
`define HIF_CFG_RST 6'h00
// Command and status fields.
`define HIF_CMD_GO 0
`define HIF_STAT_BUSY 0
`define HIF_STAT_DONE 1
`define HIF_STAT_MODE 2
`define HIF_STAT_TOUT 3
// Timing.
`define HIF_CLK_NS 25
`define HIF_CONV_NS 1600
`define HIF_CONV_CYC ((`HIF_CONV_NS + `HIF_CLK_NS - 1) / `HIF_CLK_NS)
`define HIF_TOUT_CYC (4 * `HIF_CONV_CYC)
`define HIF_STROBE_CYC 2
`define HIF_RD_CYC 4
`define HIF_SER_BITS 16
`define HIF_CTL_BITS 6
`endif

// *** shared/hif_pkg.sv ***
package hif_pkg;
    // Parallel-side pins driven by the host.
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic sample_trigger_n;
        logic [11:0] db;
        logic db_oe;
    } hif_par_t;
    // Serial-side pins driven by the host.
    typedef struct packed {
        logic sclk;
        logic serial_read_frame_n;
        logic serial_write_frame_n;
        logic sdin;
    } hif_ser_t;
    // Sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE, ST_P_ADDR, ST_P_TRIG, ST_P_WAIT, ST_P_READ, ST_S_XFER, ST_S_END
    } hif_state_t;
endpackage

// *** verif/hif_dev_model.sv ***
`timescale 1ns/1ps
// Behavioural converter seen from the host: control register, conversion timer, parallel and serial ports.
module hif_dev_model #(
    parameter int CONV_NS = 1600,
    parameter int SOFT_NS = 400
) (
    input wire logic i_mode,
    input wire hif_pkg::hif_par_t i_par,
    input wire hif_pkg::hif_ser_t i_ser,
    input wire logic i_mute,
    output logic o_eoc_n,
    output logic [11:0] o_db,
    output logic o_sdout
);
    logic [5:0] ctl = 6'h00; // Control register: high, mid, low channel, soft, standby, format.
    logic [11:0] res = 12'h000; // Output register.
    logic [15:0] word = 16'h0000; // Frame image captured when the read frame opens.
    logic [5:0] sh = 6'h00; // Serial write shifter.
    int rcnt = 0; // Read position; it survives pauses of the serial clock.
    int wcnt = 0; // Written bit count.
    initial begin
        o_eoc_n = 1'b1;
        o_sdout = 1'b0;
    end
    // One conversion: optional soft delay, full conversion time, then the result and the done pulse.
    // The sample value depends on the channel number and the format bit only, so the host can predict it exactly.
    task automatic convert(input int dly);
        #(dly + CONV_NS);
        res = (12'h123 * ({9'h000, ctl[5:3]} + 12'h001)) ^ {ctl[0], 11'h000};
        if (!i_mute) begin
            o_eoc_n = 1'b0;
            #100;
            o_eoc_n = 1'b1;
        end
    endtask
    // Store strobe rise latches the control word in parallel mode; a soft start runs the delay pulse.
    always @(posedge i_par.wr_n) if (i_mode === 1'b1) begin
        ctl = i_par.db[5:0];
        if (ctl[2]) convert(SOFT_NS);
    end
    // Trigger rise holds and converts, unless a soft start masks the pin.
    always @(posedge i_par.sample_trigger_n) if (i_mode === 1'b1 && !ctl[2]) convert(0);
    // Result is driven only while select and read are low; otherwise the lines show no stale value.
    assign o_db = (!i_par.cs_n && !i_par.rd_n) ? res : ~res;
    // Read frame opening: header from the control register, then the result MSB first.
    always @(negedge i_ser.serial_read_frame_n) begin
        rcnt = 0;
        word = {ctl[0], ctl[5:3], res};
    end
    // Data out moves on the clock rise; after the last bit it stops carrying data.
    always @(posedge i_ser.sclk) if (i_mode === 1'b0 && !i_ser.serial_read_frame_n) begin
        o_sdout = (rcnt < 16) ? word[15 - rcnt] : ~o_sdout;
        rcnt++;
    end
    always @(posedge i_ser.serial_read_frame_n) o_sdout = ~o_sdout;
    always @(negedge i_ser.serial_write_frame_n) wcnt = 0;
    // Data in is taken on the clock fall, first six bits only.
    always @(negedge i_ser.sclk) if (i_mode === 1'b0 && !i_ser.serial_write_frame_n && wcnt < 6) begin
        sh = {sh[4:0], i_ser.sdin};
        wcnt++;
    end
    // Closing the write frame commits the word; a soft start then converts.
    always @(posedge i_ser.serial_write_frame_n) if (i_mode === 1'b0 && wcnt == 6) begin
        ctl = sh;
        if (ctl[2]) convert(SOFT_NS);
    end
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`include "hif_defs.svh"
module tb_top;
    typedef struct packed {
        logic mode;
        logic [5:0] cfg;
    } hif_row_t;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_mode = 1'b0;
    logic mute = 1'b0; // Suppresses the done pulse to provoke a timeout.
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic eoc_n;
    logic [11:0] db;
    logic sdout;
    logic [31:0] rdata;
    logic busy;
    logic [31:0] v; // Last read value.
    hif_pkg::hif_par_t par;
    hif_pkg::hif_ser_t ser;
    int n_mismatch = 0;
    int checks = 0;
    // Mode and control word; serial rows return the previous conversion.
    hif_row_t rows [7] = '{{1'b1, 6'h18}, {1'b1, 6'h39}, {1'b1, 6'h04}, {1'b0, 6'h2d},
                           {1'b0, 6'h10}, {1'b0, 6'h36}, {1'b1, 6'h09}};
    logic h_fmt = 1'b0; // Format bit held by the converter.
    logic [2:0] h_ch = 3'h0; // Channel held by the converter.
    logic [11:0] last = 12'h000; // Last converted code.
    logic [15:0] exp16;
    always #12.5 i_clk = ~i_clk;
    hif_adc_host #(.SCLK_HALF(4), .TOUT_CYC(120)) dut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_mode(i_mode), .i_eoc_n(eoc_n), .i_db(db), .i_sdout(sdout),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .o_par(par),
        .o_ser(ser), .o_busy(busy));
    hif_dev_model dev (.i_mode(i_mode), .i_par(par), .i_ser(ser), .i_mute(mute), .o_eoc_n(eoc_n),
        .o_db(db), .o_sdout(sdout));
    // Expected sample code for a channel and format.
    function automatic logic [11:0] code(input logic [2:0] ch, input logic f);
        return (12'h123 * ({9'h000, ch} + 12'h001)) ^ {f, 11'h000};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge i_clk);
        wr_s <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a);
        @(posedge i_clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge i_clk);
        rd_s <= 1'b0;
        #1 v = rdata;
    endtask
    // Poll one status bit, bounded; a miss counts as a mismatch.
    task automatic wbit(input int b);
        for (int i = 0; i < 300; i++) begin
            rd(`HIF_REG_STAT);
            if (v[b] === 1'b1) break;
        end
        chk("status wait", 32'h1, {31'h0, v[b]});
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Watchdog: the whole sequence needs about 2000 cycles.
    initial begin
        #(25 * 20000);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        chk("idle pins", 32'h3, {30'h0, ser.serial_read_frame_n, ser.serial_write_frame_n});
        rd(`HIF_REG_STAT);
        chk("status reset", 32'h0, v);
        rd(`HIF_REG_CFG);
        chk("cfg reset", {26'h0, `HIF_CFG_RST}, v);
        rd(4'h2);
        chk("unmapped read", 32'h0, v);
        foreach (rows[k]) begin
            i_mode <= rows[k].mode;
            repeat (3) @(posedge i_clk);
            wr(`HIF_REG_CFG, {26'h0, rows[k].cfg});
            wr(`HIF_REG_CMD, 32'h1);
            if (!rows[k].mode) begin
                repeat (40) @(posedge i_clk);
                chk("serial pins", 32'h38001, {14'h0, par.cs_n, par.rd_n, par.wr_n, par.db, ser.serial_read_frame_n,
                    ser.serial_write_frame_n, busy});
                // A start while the frame runs must be refused; the result check below shows it.
                wr(`HIF_REG_CMD, 32'h1);
            end
            wbit(1);
            if (rows[k].mode) begin
                last = code(rows[k].cfg[5:3], rows[k].cfg[0]);
                exp16 = {rows[k].cfg[0], rows[k].cfg[5:3], last};
            end else begin
                exp16 = {h_fmt, h_ch, last};
                if (rows[k].cfg[2]) last = code(rows[k].cfg[5:3], rows[k].cfg[0]);
            end
            h_fmt = rows[k].cfg[0];
            h_ch = rows[k].cfg[5:3];
            rd(`HIF_REG_RES);
            chk("result", {16'h0, exp16}, v);
            rd(`HIF_REG_STAT);
            chk("status done", {29'h0, rows[k].mode, 2'b10}, v);
            wr(`HIF_REG_STAT, 32'h2);
            repeat (120) @(posedge i_clk);
        end
        // Silent converter: the wait must end in a timeout, not a result.
        mute <= 1'b1;
        i_mode <= 1'b1;
        repeat (3) @(posedge i_clk);
        wr(`HIF_REG_CFG, 32'h18);
        wr(`HIF_REG_CMD, 32'h1);
        wbit(3);
        rd(`HIF_REG_STAT);
        chk("status timeout", 32'hc, v);
        wr(`HIF_REG_STAT, 32'h8);
        rd(`HIF_REG_STAT);
        chk("timeout cleared", 32'h4, v);
        // Reset in mid-frame: the link must go idle at once and every flag must clear.
        i_mode <= 1'b0;
        repeat (3) @(posedge i_clk);
        wr(`HIF_REG_CMD, 32'h1);
        repeat (20) @(posedge i_clk);
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_clk);
        chk("pins in reset", 32'h3, {29'h0, ser.sclk, ser.serial_read_frame_n,
            ser.serial_write_frame_n});
        i_rstn <= 1'b1;
        rd(`HIF_REG_STAT);
        chk("status after reset", 32'h0, v);
        end_of_test();
    end
endmodule
